// >>> rtl/option_fuse_decoder_defines.vh
// Purpose: constants of the option fuse decoder
// Assumes: included by bare name from rtl files
// Notes: option word layout, register map, reset values
`ifndef OPTION_FUSE_DECODER_DEFINES_VH
`define OPTION_FUSE_DECODER_DEFINES_VH

// option word width and field positions
`define OPT_WIDTH 9
`define OPT_PROTECT 0
`define OPT_INT0_SEL 1
`define OPT_INT1_SEL 2
`define OPT_CMP_EDGE_LO 3
`define OPT_CMP_EDGE_HI 4
`define OPT_CMP_PWM_GATE 5
`define OPT_PWM_DOUBLE 6
`define OPT_TIMER_DOUBLE 7
`define OPT_TIMER_7BIT 8

// comparator edge encodings
`define CMP_EDGE_ALL 2'h0
`define CMP_EDGE_RISE 2'h1
`define CMP_EDGE_FALL 2'h2

// timer clock source code for the fast oscillator
`define TIMER_SRC_FAST 4'h2
`define TIMER_SRC_HI 7
`define TIMER_SRC_LO 4
`define TIMER_SCALE_PWM 7

// data widths
`define PROG_WIDTH 16
`define PWM_COUNT 3
`define ADDR_WIDTH 4

// register byte offsets
`define REG_STATUS 4'h0
`define REG_MASK 4'h4
`define REG_OPTION 4'h8
`define REG_STATE 4'hC

// status bits
`define STAT_WIDTH 5
`define STAT_LOADED 0
`define STAT_CMP 1
`define STAT_INT0 2
`define STAT_INT1 3
`define STAT_REFUSED 4

// reset values
`define MASK_RESET 5'h00
`define OPTION_RESET 9'h000
`define SYNC_STAGES 2

`endif

// >>> rtl/pin_sync.v
// Purpose: two flip-flop synchroniser for a group of pins
// Assumes: pins are asynchronous to core_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 4
) (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// asynchronous pins
	input wire [WIDTH-1:0] pinAsync,
	// synchronised levels
	output wire [WIDTH-1:0] pinSync
);

	reg [WIDTH-1:0] stage1_q;
	reg [WIDTH-1:0] stage2_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			// two stages per bit
			always @(posedge core_clk) begin
				if (reset) begin
					stage1_q[i] <= 1'b0;
					stage2_q[i] <= 1'b0;
				end else begin
					stage1_q[i] <= pinAsync[i];
					stage2_q[i] <= stage1_q[i];
				end
			end
		end
	endgenerate

	assign pinSync = stage2_q;

endmodule

// >>> rtl/option_fuse_decoder.v
// Purpose: load the code-option word and decode it into static configuration
// Assumes: single 20 MHz core_clk, synchronous active high reset
// Notes: options are frozen until the next reset; avalon-mm slave for status
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "option_fuse_decoder_defines.vh"

module option_fuse_decoder (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// option store read port
	output reg optReadReq,
	input wire optReadValid,
	input wire [`OPT_WIDTH-1:0] optReadData,
	output reg coreReset,
	// program read-back
	input wire readbackReq,
	input wire [`PROG_WIDTH-1:0] progWord,
	output reg readbackValid,
	output reg readbackRefused,
	output reg [`PROG_WIDTH-1:0] readbackData,
	// port pins and comparator
	input wire portA0,
	input wire portA4,
	input wire portB0,
	input wire portB5,
	input wire cmpOut,
	// interrupt slots
	output reg intSlot0,
	output reg intSlot1,
	output reg cmpIrq,
	// pwm outputs
	input wire [`PWM_COUNT-1:0] pwmIn,
	output reg [`PWM_COUNT-1:0] pwmOut,
	// pwm generator clock
	input wire pwmGenClkSel0,
	output reg pwmGenUseFast,
	output reg pwmGenDouble,
	// timer clocks and resolution
	input wire [7:0] timer2_control,
	input wire [7:0] timer3_control,
	input wire [7:0] timer2_scale,
	input wire [7:0] timer3_scale,
	output reg timer2UseFast,
	output reg timer3UseFast,
	output reg timer2Double,
	output reg timer3Double,
	output reg timer2Pwm7Bit,
	output reg timer3Pwm7Bit,
	output reg timer2Pwm6Bit,
	output reg timer3Pwm6Bit,
	// avalon-mm slave
	input wire [`ADDR_WIDTH-1:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output reg waitrequest,
	// interrupt
	output reg irq
);

	// load sequencer states
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_REQ = 4'h2;
	localparam [3:0] ST_WAIT = 4'h4;
	localparam [3:0] ST_DONE = 4'h8;

	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [`OPT_WIDTH-1:0] option_q;
	reg [`STAT_WIDTH-1:0] status_q;
	reg [`STAT_WIDTH-1:0] status_d;
	reg [`STAT_WIDTH-1:0] mask_q;
	reg cmpPrev_q;
	reg int0Prev_q;
	reg int1Prev_q;
	reg loadedPulse;

	wire [4:0] pinSync;
	wire pa0Sync;
	wire pa4Sync;
	wire pb0Sync;
	wire pb5Sync;
	wire cmpSync;
	wire loaded;
	wire [1:0] cmpEdgeSel;
	wire cmpRise;
	wire cmpFall;
	wire cmpEvent;
	wire slot0Level;
	wire slot1Level;
	wire accessTaken;
	wire [`STAT_WIDTH-1:0] clearBits;
	wire refuseEvent;

	// pin synchronisers
	pin_sync #(
		.WIDTH(5)
	) u_pin_sync (
		.core_clk(core_clk),
		.reset(reset),
		.pinAsync({cmpOut, portB5, portB0, portA4, portA0}),
		.pinSync(pinSync)
	);

	assign pa0Sync = pinSync[0];
	assign pa4Sync = pinSync[1];
	assign pb0Sync = pinSync[2];
	assign pb5Sync = pinSync[3];
	assign cmpSync = pinSync[4];

	// true when a timer source field selects the fast oscillator
	function srcIsFast;
		input [7:0] ctrl;
		begin
			srcIsFast = (ctrl[`TIMER_SRC_HI:`TIMER_SRC_LO] == `TIMER_SRC_FAST);
		end
	endfunction

	// option load sequencer next state
	always @* begin
		state_d = state_q;
		loadedPulse = 1'b0;
		case (state_q)
			ST_IDLE: begin
				state_d = ST_REQ;
			end
			ST_REQ: begin
				state_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (optReadValid) begin
					state_d = ST_DONE;
					loadedPulse = 1'b1;
				end
			end
			ST_DONE: begin
				state_d = ST_DONE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// sequencer and option latch, no write path from software
	always @(posedge core_clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			option_q <= `OPTION_RESET;
			optReadReq <= 1'b0;
			coreReset <= 1'b1;
		end else begin
			state_q <= state_d;
			optReadReq <= (state_q == ST_IDLE); // one-cycle request
			if (loadedPulse) begin
				option_q <= optReadData;
			end
			coreReset <= ~(loadedPulse | loaded);
		end
	end

	assign loaded = (state_q == ST_DONE);
	assign cmpEdgeSel = option_q[`OPT_CMP_EDGE_HI:`OPT_CMP_EDGE_LO];

	// interrupt slot routing
	assign slot0Level = option_q[`OPT_INT0_SEL] ? pb5Sync : pa0Sync;
	assign slot1Level = option_q[`OPT_INT1_SEL] ? pa4Sync : pb0Sync;

	// comparator edge choice
	assign cmpRise = cmpSync & ~cmpPrev_q;
	assign cmpFall = ~cmpSync & cmpPrev_q;
	assign cmpEvent = loaded & (((cmpEdgeSel == `CMP_EDGE_ALL) & (cmpRise | cmpFall)) |
		((cmpEdgeSel == `CMP_EDGE_RISE) & cmpRise) |
		((cmpEdgeSel == `CMP_EDGE_FALL) & cmpFall));

	// read-back refusal
	assign refuseEvent = readbackReq & loaded & option_q[`OPT_PROTECT];

	// decoded outputs, held low until options are loaded, except pwmOut, which follows pwmIn from reset release
	always @(posedge core_clk) begin
		if (reset) begin
			intSlot0 <= 1'b0;
			intSlot1 <= 1'b0;
			cmpIrq <= 1'b0;
			cmpPrev_q <= 1'b0;
			int0Prev_q <= 1'b0;
			int1Prev_q <= 1'b0;
			pwmOut <= {`PWM_COUNT{1'b0}};
			pwmGenUseFast <= 1'b0;
			pwmGenDouble <= 1'b0;
			timer2UseFast <= 1'b0;
			timer3UseFast <= 1'b0;
			timer2Double <= 1'b0;
			timer3Double <= 1'b0;
			timer2Pwm7Bit <= 1'b0;
			timer3Pwm7Bit <= 1'b0;
			timer2Pwm6Bit <= 1'b0;
			timer3Pwm6Bit <= 1'b0;
		end else begin
			cmpPrev_q <= cmpSync;
			int0Prev_q <= slot0Level;
			int1Prev_q <= slot1Level;
			intSlot0 <= loaded & slot0Level;
			intSlot1 <= loaded & slot1Level;
			cmpIrq <= cmpEvent;
			// comparator low blanks every pwm output when gated
			if (option_q[`OPT_CMP_PWM_GATE]) begin
				pwmOut <= pwmIn & {`PWM_COUNT{cmpSync}};
			end else begin
				pwmOut <= pwmIn;
			end
			pwmGenUseFast <= loaded & pwmGenClkSel0;
			pwmGenDouble <= loaded & pwmGenClkSel0 & option_q[`OPT_PWM_DOUBLE];
			timer2UseFast <= loaded & srcIsFast(timer2_control);
			timer3UseFast <= loaded & srcIsFast(timer3_control);
			timer2Double <= loaded & srcIsFast(timer2_control) &
				option_q[`OPT_TIMER_DOUBLE];
			timer3Double <= loaded & srcIsFast(timer3_control) &
				option_q[`OPT_TIMER_DOUBLE];
			timer2Pwm7Bit <= loaded & timer2_scale[`TIMER_SCALE_PWM] &
				option_q[`OPT_TIMER_7BIT];
			timer3Pwm7Bit <= loaded & timer3_scale[`TIMER_SCALE_PWM] &
				option_q[`OPT_TIMER_7BIT];
			timer2Pwm6Bit <= loaded & timer2_scale[`TIMER_SCALE_PWM] &
				~option_q[`OPT_TIMER_7BIT];
			timer3Pwm6Bit <= loaded & timer3_scale[`TIMER_SCALE_PWM] &
				~option_q[`OPT_TIMER_7BIT];
		end
	end

	// program read-back port
	always @(posedge core_clk) begin
		if (reset) begin
			readbackValid <= 1'b0;
			readbackRefused <= 1'b0;
			readbackData <= {`PROG_WIDTH{1'b0}};
		end else begin
			readbackValid <= readbackReq & loaded & ~option_q[`OPT_PROTECT];
			readbackRefused <= refuseEvent;
			if (readbackReq & loaded & ~option_q[`OPT_PROTECT]) begin
				readbackData <= progWord;
			end else begin
				readbackData <= {`PROG_WIDTH{1'b0}};
			end
		end
	end

	// bus handshake: one wait cycle, then waitrequest low for one cycle
	assign accessTaken = (read | write) & ~waitrequest;
	assign clearBits = (write & ~waitrequest & (address == `REG_STATUS)) ?
		writedata[`STAT_WIDTH-1:0] : {`STAT_WIDTH{1'b0}};

	// sticky status, set wins over write-one-to-clear
	always @* begin
		status_d = status_q & ~clearBits;
		status_d[`STAT_LOADED] = status_d[`STAT_LOADED] | loadedPulse;
		status_d[`STAT_CMP] = status_d[`STAT_CMP] | cmpEvent;
		status_d[`STAT_INT0] = status_d[`STAT_INT0] | (loaded & slot0Level & ~int0Prev_q);
		status_d[`STAT_INT1] = status_d[`STAT_INT1] | (loaded & slot1Level & ~int1Prev_q);
		status_d[`STAT_REFUSED] = status_d[`STAT_REFUSED] | refuseEvent;
	end

	// register file and bus slave
	always @(posedge core_clk) begin
		if (reset) begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
			status_q <= {`STAT_WIDTH{1'b0}};
			mask_q <= `MASK_RESET;
			irq <= 1'b0;
		end else begin
			status_q <= status_d;
			irq <= |(status_d & mask_q);
			if ((read | write) & waitrequest) begin
				waitrequest <= 1'b0;
			end else begin
				waitrequest <= 1'b1;
			end
			// read data captured as waitrequest drops
			if (read & waitrequest) begin
				case (address)
					`REG_STATUS: readdata <= {27'h0000000, status_q};
					`REG_MASK: readdata <= {27'h0000000, mask_q};
					`REG_OPTION: readdata <= {23'h000000, option_q};
					`REG_STATE: readdata <= {28'h0000000, state_q};
					default: readdata <= 32'h00000000;
				endcase
			end
			if (accessTaken & write & (address == `REG_MASK)) begin
				mask_q <= writedata[`STAT_WIDTH-1:0];
			end
		end
	end

endmodule

// >>> verif/option_fuse_decoder_props.sv
// Purpose: assertions on the option fuse decoder ports
// Assumes: bound to the top module, one clock domain
// Notes: option word captured where the design takes it
`timescale 1ns/1ps
`include "option_fuse_decoder_defines.vh"
module option_fuse_decoder_props (
	// clock, reset and load
	input wire core_clk,
	input wire reset,
	input wire optReadReq,
	input wire optReadValid,
	input wire coreReset,
	input wire [`OPT_WIDTH-1:0] optReadData,
	// read-back
	input wire readbackReq,
	input wire readbackValid,
	input wire readbackRefused,
	input wire [`PROG_WIDTH-1:0] progWord,
	input wire [`PROG_WIDTH-1:0] readbackData,
	// pins and decoded outputs
	input wire portA0,
	input wire portA4,
	input wire portB0,
	input wire portB5,
	input wire cmpOut,
	input wire intSlot0,
	input wire intSlot1,
	input wire cmpIrq,
	input wire [`PWM_COUNT-1:0] pwmIn,
	input wire [`PWM_COUNT-1:0] pwmOut,
	input wire [7:0] timer2_control,
	input wire [7:0] timer2_scale,
	input wire timer2UseFast,
	input wire timer2Pwm7Bit,
	input wire timer2Pwm6Bit,
	// bus handshake
	input wire read,
	input wire write,
	input wire waitrequest
);
	reg [`OPT_WIDTH-1:0] optQ;
	wire rb = readbackReq && !coreReset;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// option word as the design takes it
	always @(posedge core_clk) begin
		if (coreReset && optReadValid)
			optQ <= optReadData;
	end
	load_hold_a: assert property (!coreReset |=> !coreReset && !optReadReq)
		else $error("option load repeated");
	rb_refuse_a: assert property (
		rb && optQ[0] |=> readbackRefused && !readbackValid && readbackData == 0)
		else $error("protected word returned");
	rb_return_a: assert property (
		rb && !optQ[0] |=> readbackValid && readbackData == $past(progWord))
		else $error("readable word not returned");
	slot0_pin_a: assert property (
		!$past(coreReset, 3) |-> intSlot0 == (optQ[1] ? $past(portB5, 3) : $past(portA0, 3)))
		else $error("slot 0 wrong pin");
	slot1_pin_a: assert property (
		!$past(coreReset, 3) |-> intSlot1 == (optQ[2] ? $past(portA4, 3) : $past(portB0, 3)))
		else $error("slot 1 wrong pin");
	cmp_edge_a: assert property (!$past(coreReset, 6) |-> cmpIrq ==
		($past(cmpOut, 3) && !$past(cmpOut, 4) && !optQ[4] ||
		!$past(cmpOut, 3) && $past(cmpOut, 4) && !optQ[3]))
		else $error("comparator edge mismatch");
	pwm_gate_a: assert property (!$past(coreReset, 3) |-> pwmOut ==
		(optQ[5] ? $past(pwmIn) & {`PWM_COUNT{$past(cmpOut, 3)}} : $past(pwmIn)))
		else $error("pwm gating mismatch");
	timer_src_a: assert property (
		!$past(coreReset, 2) |-> timer2UseFast == ($past(timer2_control[7:4]) == `TIMER_SRC_FAST))
		else $error("timer source mismatch");
	pwm_res_a: assert property (!$past(coreReset, 2) && $past(timer2_scale[7]) |->
		timer2Pwm7Bit == optQ[8] && timer2Pwm6Bit == !optQ[8])
		else $error("timer resolution mismatch");
	bus_wait_a: assert property ($rose(read) || $rose(write) |=> !waitrequest ##1 waitrequest)
		else $error("bus wait mismatch");
	cover property (rb && optQ[0]);
	cover property (cmpIrq);
	cover property (read && !waitrequest);
endmodule
bind option_fuse_decoder option_fuse_decoder_props u_props (
	.core_clk(core_clk), .reset(reset), .optReadReq(optReadReq), .optReadValid(optReadValid),
	.coreReset(coreReset), .optReadData(optReadData), .readbackReq(readbackReq),
	.readbackValid(readbackValid), .readbackRefused(readbackRefused), .progWord(progWord),
	.readbackData(readbackData), .portA0(portA0), .portA4(portA4), .portB0(portB0),
	.portB5(portB5), .cmpOut(cmpOut), .intSlot0(intSlot0), .intSlot1(intSlot1),
	.cmpIrq(cmpIrq), .pwmIn(pwmIn), .pwmOut(pwmOut), .timer2_control(timer2_control),
	.timer2_scale(timer2_scale), .timer2UseFast(timer2UseFast),
	.timer2Pwm7Bit(timer2Pwm7Bit), .timer2Pwm6Bit(timer2Pwm6Bit), .read(read),
	.write(write), .waitrequest(waitrequest)
);

// >>> verif/option_fuse_decoder_test.sv
// Purpose: self-checking bench for the option fuse decoder
// Assumes: 20 MHz core_clk, reset held eleven cycles
// Notes: four option words cover every edge mode and pin choice
`timescale 1ns/1ps
`include "option_fuse_decoder_defines.vh"
module option_fuse_decoder_test;
	logic core_clk, reset, optReadValid, readbackReq, portA0, portA4, portB0, portB5, cmpOut;
	logic pwmGenClkSel0, read, write, optReadReq, coreReset, readbackValid, readbackRefused;
	logic intSlot0, intSlot1, cmpIrq, pwmGenUseFast, pwmGenDouble, timer2UseFast, timer3UseFast;
	logic timer2Double, timer3Double, timer2Pwm7Bit, timer3Pwm7Bit, timer2Pwm6Bit, timer3Pwm6Bit;
	logic waitrequest, irq;
	logic [`OPT_WIDTH-1:0] optReadData, w;
	logic [`PROG_WIDTH-1:0] progWord, readbackData;
	logic [`PWM_COUNT-1:0] pwmIn, pwmOut;
	logic [7:0] timer2_control, timer3_control, timer2_scale, timer3_scale;
	logic [`ADDR_WIDTH-1:0] address;
	logic [31:0] writedata, readdata, rd;
	logic [`OPT_WIDTH-1:0] cfg [4] = '{9'h16B, 9'h094, 9'h0E6, 9'h119};
	int n_fail = 0, n_tests = 0, nIrq = 0, nBase;
	wire [9:0] clkFlags = {pwmGenUseFast, pwmGenDouble, timer2UseFast, timer3UseFast,
		timer2Double, timer3Double, timer2Pwm7Bit, timer2Pwm6Bit, timer3Pwm7Bit, timer3Pwm6Bit};
	option_fuse_decoder DUT (
		.core_clk(core_clk), .reset(reset), .optReadReq(optReadReq),
		.optReadValid(optReadValid), .optReadData(optReadData), .coreReset(coreReset),
		.readbackReq(readbackReq), .progWord(progWord), .readbackValid(readbackValid),
		.readbackRefused(readbackRefused), .readbackData(readbackData),
		.portA0(portA0), .portA4(portA4), .portB0(portB0), .portB5(portB5), .cmpOut(cmpOut),
		.intSlot0(intSlot0), .intSlot1(intSlot1), .cmpIrq(cmpIrq),
		.pwmIn(pwmIn), .pwmOut(pwmOut), .pwmGenClkSel0(pwmGenClkSel0),
		.pwmGenUseFast(pwmGenUseFast), .pwmGenDouble(pwmGenDouble),
		.timer2_control(timer2_control), .timer3_control(timer3_control),
		.timer2_scale(timer2_scale), .timer3_scale(timer3_scale),
		.timer2UseFast(timer2UseFast), .timer3UseFast(timer3UseFast),
		.timer2Double(timer2Double), .timer3Double(timer3Double),
		.timer2Pwm7Bit(timer2Pwm7Bit), .timer3Pwm7Bit(timer3Pwm7Bit),
		.timer2Pwm6Bit(timer2Pwm6Bit), .timer3Pwm6Bit(timer3Pwm6Bit),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .irq(irq)
	);
	// clock
	initial begin
		core_clk = 0;
		forever #25 core_clk = ~core_clk;
	end
	// comparator interrupt pulse count
	always @(posedge core_clk) begin
		if (cmpIrq === 1'b1)
			nIrq <= nIrq + 1;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// one avalon access, held until waitrequest is seen low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 20);
		rd = readdata;
		read <= 0;
		write <= 0;
		if (k == 20)
			chk(waitrequest, 0);
	endtask
	// reset, then answer the option load request with word o
	task start(input logic [8:0] o);
		int k;
		@(posedge core_clk) reset <= 1;
		tick(10);
		@(posedge core_clk) reset <= 0;
		k = 0;
		while (optReadReq !== 1'b1 && k < 20) begin
			tick(1);
			k++;
		end
		@(posedge core_clk) begin
			optReadValid <= 1;
			optReadData <= o;
		end
		@(posedge core_clk) optReadValid <= 0;
		tick(2);
	endtask
	task report_and_stop;
		$display("tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#200000;
		n_fail++;
		report_and_stop;
	end
	initial begin
		reset = 1;
		{optReadValid, readbackReq, portA0, portA4, portB0, portB5, cmpOut, read, write} = '0;
		{optReadData, progWord, pwmIn, address, writedata, timer3_scale} = '0;
		{pwmGenClkSel0, timer2_control, timer3_control, timer2_scale} = {1'b1, 24'h2F3F80};
		for (int e = 0; e < 4; e++) begin
			w = cfg[e];
			start(w);
			chk(coreReset, 0);
			@(posedge core_clk) begin
				readbackReq <= 1;
				progWord <= 16'hA5C3;
			end
			@(posedge core_clk) readbackReq <= 0;
			#1 chk({readbackValid, readbackRefused, readbackData},
				{!w[0], w[0], w[0] ? 16'h0000 : 16'hA5C3});
			for (int v = 0; v < 2; v++) begin
				@(posedge core_clk) {portA0, portB5, portB0, portA4} <= {v[0], !v[0], !v[0], v[0]};
				tick(4);
				chk(intSlot0, w[1] ? !v[0] : v[0]);
				chk(intSlot1, w[2] ? v[0] : !v[0]);
			end
			nBase = nIrq;
			@(posedge core_clk) begin
				cmpOut <= 1;
				pwmIn <= 3'h5;
			end
			tick(8);
			chk(nIrq - nBase, 1 - w[4]);
			chk(pwmOut, 3'h5);
			@(posedge core_clk) cmpOut <= 0;
			tick(8);
			chk(nIrq - nBase, 2 - w[4] - w[3]);
			chk(pwmOut, w[5] ? 3'h0 : 3'h5);
			chk(clkFlags, {1'b1, w[6], 2'b10, w[7], 1'b0, w[8], !w[8], 2'b00});
			// swap the selects: generator off, timer three on the fast osc with pwm
			@(posedge core_clk) {pwmGenClkSel0, timer2_control, timer3_control, timer2_scale,
				timer3_scale} <= {1'b0, 32'h3F200080};
			tick(2);
			chk(clkFlags, {4'b0001, 1'b0, w[7], 2'b00, w[8], !w[8]});
			@(posedge core_clk) {pwmGenClkSel0, timer2_control, timer3_control, timer2_scale,
				timer3_scale} <= {1'b1, 32'h2F3F8000};
			bus(0, `REG_MASK, 0);
			chk(rd, 0);
			bus(1, `REG_OPTION, ~w);
			bus(0, `REG_OPTION, 0);
			chk(rd, w);
			bus(0, `REG_STATUS, 0);
			chk(rd, {w[0], 3'h6 | !(w[4] & w[3]), 1'b1});
			chk(irq, 0);
			bus(1, `REG_MASK, 32'h1F);
			tick(2);
			chk(irq, 1);
			bus(1, `REG_STATUS, 32'h1F);
			tick(2);
			chk(irq, 0);
			bus(0, 4'h2, 0);
			chk(rd, 0);
			bus(0, `REG_STATE, 0);
			chk(rd, 8);
		end
		report_and_stop;
	end
endmodule
